// ===== core/rdg_status_gpio.sv
// Status logic of the radio data decoder and the three general pins.
// Assumes the symbol decoder delivers one strobe per decoded group,
// and that all inputs are synchronous to CLK_SYS.
`timescale 1ns/1ns
`default_nettype none

`include "rdg_defines.svh"

module rdg_status_gpio
	import rdg_pkg::*;
#(
	parameter int unsigned READY_HOLD_CYCLES = `RDG_READY_HOLD_CYC,
	parameter int unsigned IRQ_PULSE_CYCLES = `RDG_IRQ_PULSE_CYC
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// Host control bits
	input wire logic RDS_ENABLE,
	input wire logic DETAIL_REPORT_SELECT,
	input wire logic GROUP_IRQ_ENABLE,
	input wire logic SEEK_IRQ_ENABLE,
	input wire logic [5:0] PIN_CONFIG,
	input wire logic GAIN_LOOP_DISABLE,
	// Symbol decoder and tuner events
	input wire rdg_group_type GROUP_REPORT,
	input wire logic STREAM_IN_SYNC,
	input wire logic SEEK_TUNE_DONE,
	input wire logic STEREO_DETECTED,
	// Levels seen on the three pins
	input wire logic [2:0] GENERAL_PIN_IN,
	// Status and control seen by the host
	output rdg_status_type STATUS,
	output logic GAIN_LOOP_OFF,
	output logic BUS_MODE_VALID,
	output logic BUS_MODE_THREE_WIRE,
	// Pin drivers, enable high while driving
	output logic [2:0] GENERAL_PIN_OUT,
	output logic [2:0] GENERAL_PIN_OE,
	output logic [2:0] GENERAL_PIN_LEVEL,
	output logic PIN_THREE_PULL_DOWN
);

	// Sort a block's bit error count into its two bit level
	function automatic logic [1:0] err_level(input logic [3:0] n);
		logic [1:0] lvl;
		lvl = `RDG_ERR_MANY;
		if (n == 4'h0) begin
			lvl = `RDG_ERR_NONE;
		end else if (n <= `RDG_ERR_FEW_MAX) begin
			lvl = `RDG_ERR_FEW;
		end else if (n <= `RDG_ERR_SOME_MAX) begin
			lvl = `RDG_ERR_SOME;
		end
		return lvl;
	endfunction : err_level

	// Drive of one pin from its two bit field: {oe, out}
	function automatic logic [1:0] pin_drive(input logic [1:0] field,
		input logic alt_ok, input logic alt_val);
		logic [1:0] drv;
		drv = 2'h0;
		case (field)
			`RDG_FUNC_HIZ: begin
				drv = 2'h0;
			end
			`RDG_FUNC_ALT: begin
				// Pins without an alternate use stay undriven
				if (alt_ok) begin
					drv = {1'b1, alt_val};
				end else begin
					drv = 2'h0;
				end
			end
			`RDG_FUNC_LOW: begin
				drv = 2'h2;
			end
			`RDG_FUNC_HIGH: begin
				drv = 2'h3;
			end
			default: begin
				drv = 2'h0;
			end
		endcase
		return drv;
	endfunction : pin_drive

	// Registered state and its next value
	rdg_state_type st_ff;
	rdg_state_type nxt_st;

	// Group and interrupt events
	logic detail_mode;
	logic group_hit;
	logic seek_rise;
	logic pin_two_irq_mode;
	logic irq_start;

	// Hold timer outputs
	logic ready_active;
	logic irq_active;

	// Per pin drive and alternate function values
	logic [2:0] drv_out;
	logic [2:0] drv_oe;
	logic [2:0] alt_ok;
	logic [2:0] alt_val;

	// Error level of each block of the current group, A first
	logic [3:0][1:0] new_level;

	// Reporting mode: low is standard (default), high is detailed
	assign detail_mode = DETAIL_REPORT_SELECT;

	// A group counts when data handling is on. Standard mode wants
	// a valid group; detailed mode wants lock, whatever the errors.
	always_comb begin
		group_hit = 1'b0;
		if (RDS_ENABLE && GROUP_REPORT.strobe) begin
			if (detail_mode) begin
				group_hit = STREAM_IN_SYNC;
			end else begin
				group_hit = GROUP_REPORT.valid;
			end
		end
	end

	// Seek or tune completion also pulses pin two when enabled
	assign seek_rise = SEEK_TUNE_DONE & ~st_ff.seek_done_d;

	// Pin two acts as an interrupt only with function field 01
	assign pin_two_irq_mode =
		(PIN_CONFIG[`RDG_PIN_TWO_LSB +: 2] == `RDG_FUNC_ALT);

	// Interrupt pulse start: group events need the group enable
	assign irq_start = pin_two_irq_mode &
		((group_hit & GROUP_IRQ_ENABLE) | (seek_rise & SEEK_IRQ_ENABLE));

	// Ready flag hold, retriggered by every counted group; a burst of
	// groups therefore never shortens the flag below the full hold
	rdg_hold_timer #(
		.HOLD_CYCLES(READY_HOLD_CYCLES)
	) u_ready_hold (
		.clk_sys(CLK_SYS),
		.reset(RESET),
		.start(group_hit),
		.active(ready_active)
	);

	// Pin two low pulse hold; the pin is registered once more after
	// the timer, so the host sees a clean low without glitches
	rdg_hold_timer #(
		.HOLD_CYCLES(IRQ_PULSE_CYCLES)
	) u_irq_pulse (
		.clk_sys(CLK_SYS),
		.reset(RESET),
		.start(irq_start),
		.active(irq_active)
	);

	// Alternate pin uses: pin one has none, pin two is the low going
	// interrupt (idle high), pin three shows stereo reception
	assign alt_ok = 3'h6;
	assign alt_val = {STEREO_DETECTED, ~irq_active, 1'b1};

	// Per pin drive decode; plain input/output use does not look at
	// the data enable or any other enable bit
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin
			logic [1:0] drv;
			assign drv = pin_drive(PIN_CONFIG[2*gi +: 2], alt_ok[gi], alt_val[gi]);
			assign drv_oe[gi] = drv[1];
			assign drv_out[gi] = drv[0];
		end
	endgenerate

	// One error level decoder per block; the levels only reach the
	// status when the group is counted in detailed mode
	generate
		for (gi = 0; gi < 4; gi++) begin : g_level
			assign new_level[gi] = err_level(GROUP_REPORT.bit_errors[gi]);
		end
	endgenerate

	// Next state
	always_comb begin
		nxt_st = st_ff;

		// Gain loop disable is passed to the amplifier control
		nxt_st.gain_off = GAIN_LOOP_DISABLE;

		// Bus mode straps are caught in the first cycle after the
		// release, while every pin is still undriven
		if (!st_ff.strap_valid) begin
			nxt_st.strap_valid = 1'b1;
			nxt_st.three_wire = GENERAL_PIN_IN[2] & ~GENERAL_PIN_IN[0];
		end

		// Ready flag is forced low while data handling is off
		nxt_st.stat.group_ready_flag = RDS_ENABLE & ready_active;

		// Sync flag exists only in detailed mode
		nxt_st.stat.stream_sync_flag =
			RDS_ENABLE & detail_mode & STREAM_IN_SYNC;

		// Error levels: zero in standard mode or when disabled,
		// otherwise updated with each group while locked
		if (!RDS_ENABLE || !detail_mode) begin
			nxt_st.stat.block_a_error_level = `RDG_LEVEL_RST;
			nxt_st.stat.block_b_error_level = `RDG_LEVEL_RST;
			nxt_st.stat.block_c_error_level = `RDG_LEVEL_RST;
			nxt_st.stat.block_d_error_level = `RDG_LEVEL_RST;
		end else if (group_hit) begin
			nxt_st.stat.block_a_error_level = new_level[0];
			nxt_st.stat.block_b_error_level = new_level[1];
			nxt_st.stat.block_c_error_level = new_level[2];
			nxt_st.stat.block_d_error_level = new_level[3];
		end

		// Seek completion edge detector
		nxt_st.seek_done_d = SEEK_TUNE_DONE;

		// Pins stay undriven until the straps have been taken
		nxt_st.pin_out = drv_out;
		nxt_st.pin_oe = st_ff.strap_valid ? drv_oe : `RDG_PIN_RST;

		// Pin levels for read back
		nxt_st.pin_level = GENERAL_PIN_IN;
	end

	// State register
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Status and control outputs, straight from the state register
	assign STATUS = st_ff.stat;
	assign GAIN_LOOP_OFF = st_ff.gain_off;

	// Bus mode result, valid from the first edge after release
	assign BUS_MODE_VALID = st_ff.strap_valid;
	assign BUS_MODE_THREE_WIRE = st_ff.three_wire;

	// Pin drive and read back, all registered
	assign GENERAL_PIN_OUT = st_ff.pin_out;
	assign GENERAL_PIN_OE = st_ff.pin_oe;
	assign GENERAL_PIN_LEVEL = st_ff.pin_level;

	// Weak pull-down on pin three only while reset is held
	assign PIN_THREE_PULL_DOWN = RESET;

endmodule : rdg_status_gpio

`default_nettype wire

// ===== core/rdg_defines.svh
// Constants of the radio data status and general pin block.
// Assumes the includer runs on a 250 MHz system clock.
`ifndef RDG_DEFINES_SVH
`define RDG_DEFINES_SVH

// System clock rate in kHz, used to turn times into cycles
`define RDG_CLK_KHZ 250000

// Group ready hold time and pin two low pulse time, in ms
`define RDG_READY_HOLD_MS 40
`define RDG_IRQ_PULSE_MS 5
`define RDG_READY_HOLD_CYC (`RDG_READY_HOLD_MS * `RDG_CLK_KHZ)
`define RDG_IRQ_PULSE_CYC (`RDG_IRQ_PULSE_MS * `RDG_CLK_KHZ)

// Width of the hold counters, enough for the longer hold
`define RDG_TIMER_W 24

// Pin configuration field positions, two bits per pin
`define RDG_PIN_ONE_LSB 0
`define RDG_PIN_TWO_LSB 2
`define RDG_PIN_THREE_LSB 4

// Pin function encodings
`define RDG_FUNC_HIZ 2'h0
`define RDG_FUNC_ALT 2'h1
`define RDG_FUNC_LOW 2'h2
`define RDG_FUNC_HIGH 2'h3

// Error level codes and the bit error thresholds behind them
`define RDG_ERR_NONE 2'h0
`define RDG_ERR_FEW 2'h1
`define RDG_ERR_SOME 2'h2
`define RDG_ERR_MANY 2'h3
`define RDG_ERR_FEW_MAX 4'h2
`define RDG_ERR_SOME_MAX 4'h5

// Reset values
`define RDG_LEVEL_RST 2'h0
`define RDG_PIN_RST 3'h0

`endif

// ===== core/rdg_pkg.sv
// Types shared by the radio data status and general pin block.
// Assumes rdg_defines.svh is reachable on the include path.
`include "rdg_defines.svh"

package rdg_pkg;

	// One decoded group as the symbol decoder hands it over
	typedef struct packed {
		logic strobe;
		logic valid;
		logic [3:0][3:0] bit_errors;
	} rdg_group_type;

	// Status seen by the host
	typedef struct packed {
		logic group_ready_flag;
		logic stream_sync_flag;
		logic [1:0] block_a_error_level;
		logic [1:0] block_b_error_level;
		logic [1:0] block_c_error_level;
		logic [1:0] block_d_error_level;
	} rdg_status_type;

	// State of one hold timer
	typedef struct packed {
		logic active;
		logic [`RDG_TIMER_W-1:0] cnt;
	} rdg_timer_type;

	// State of the status and pin block
	typedef struct packed {
		rdg_status_type stat;
		logic seek_done_d;
		logic strap_valid;
		logic three_wire;
		logic gain_off;
		logic [2:0] pin_out;
		logic [2:0] pin_oe;
		logic [2:0] pin_level;
	} rdg_state_type;

endpackage : rdg_pkg

// ===== core/rdg_hold_timer.sv
// Retriggerable hold timer: output high for a fixed number of cycles.
// Assumes one clock and an asynchronous active high reset.
`timescale 1ns/1ns
`default_nettype none

`include "rdg_defines.svh"

module rdg_hold_timer
	import rdg_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = 1
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic start,
	output logic active
);

	localparam logic [`RDG_TIMER_W-1:0] LOAD_VAL = `RDG_TIMER_W'(HOLD_CYCLES - 1);

	rdg_timer_type tm_ff;
	rdg_timer_type nxt_tm;

	// Start reloads, so a new event always gets the full hold
	always_comb begin
		nxt_tm = tm_ff;
		if (start) begin
			nxt_tm.active = 1'b1;
			nxt_tm.cnt = LOAD_VAL;
		end else if (tm_ff.cnt != '0) begin
			nxt_tm.cnt = tm_ff.cnt - 1'b1;
		end else begin
			nxt_tm.active = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tm_ff <= '0;
		end else begin
			tm_ff <= nxt_tm;
		end
	end

	assign active = tm_ff.active;

endmodule : rdg_hold_timer

`default_nettype wire

// ===== verif/rdg_status_props.sv
// Checker for the radio data status and pin block, bound to its top.
// Assumes small hold counts, handed on by the bind.
`timescale 1ns/1ns
`default_nettype none
module rdg_status_props
	import rdg_pkg::*;
#(
	parameter int unsigned READY_HOLD_CYCLES = 40,
	parameter int unsigned IRQ_PULSE_CYCLES = 5
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic RDS_ENABLE,
	input wire logic DETAIL_REPORT_SELECT,
	input wire logic GROUP_IRQ_ENABLE,
	input wire logic SEEK_IRQ_ENABLE,
	input wire logic [5:0] PIN_CONFIG,
	input wire rdg_group_type GROUP_REPORT,
	input wire logic STREAM_IN_SYNC,
	input wire logic SEEK_TUNE_DONE,
	input wire logic [2:0] GENERAL_PIN_IN,
	input wire rdg_status_type STATUS,
	input wire logic BUS_MODE_VALID,
	input wire logic BUS_MODE_THREE_WIRE,
	input wire logic [2:0] GENERAL_PIN_OUT,
	input wire logic [2:0] GENERAL_PIN_OE,
	input wire logic PIN_THREE_PULL_DOWN
);
	logic seek_d_ff;
	logic [23:0] hi_cnt_ff;
	logic [23:0] lo_cnt_ff;
	logic [7:0] lv_ff;
	logic take_w;
	logic irq_w;
	logic [7:0] lv_w;
	function automatic logic [1:0] lvl(input logic [3:0] n);
		return (n == 4'h0) ? 2'h0 : (n <= 4'h2) ? 2'h1 : (n <= 4'h5) ? 2'h2 : 2'h3;
	endfunction : lvl
	// Counted group, pin two interrupt cause, expected levels
	assign take_w = GROUP_REPORT.strobe && RDS_ENABLE &&
		(DETAIL_REPORT_SELECT ? STREAM_IN_SYNC : GROUP_REPORT.valid);
	assign irq_w = PIN_CONFIG[3:2] == 2'h1 && (take_w && GROUP_IRQ_ENABLE ||
		SEEK_TUNE_DONE && !seek_d_ff && SEEK_IRQ_ENABLE);
	assign lv_w = {lvl(GROUP_REPORT.bit_errors[0]), lvl(GROUP_REPORT.bit_errors[1]),
		lvl(GROUP_REPORT.bit_errors[2]), lvl(GROUP_REPORT.bit_errors[3])};
	// Run lengths of ready high and pin two low, latched levels
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			seek_d_ff <= 1'h0;
			hi_cnt_ff <= 24'h0;
			lo_cnt_ff <= 24'h0;
			lv_ff <= 8'h0;
		end else begin
			seek_d_ff <= SEEK_TUNE_DONE;
			hi_cnt_ff <= STATUS.group_ready_flag ? hi_cnt_ff + 24'h1 : 24'h0;
			lo_cnt_ff <= GENERAL_PIN_OUT[1] ? 24'h0 : lo_cnt_ff + 24'h1;
			if (take_w) begin
				lv_ff <= lv_w;
			end
		end
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	sequence s_take;
		take_w;
	endsequence
	sequence s_irq;
		irq_w ##1 PIN_CONFIG[3:2] == 2'h1;
	endsequence
	chk_ready_start: assert property (s_take ##1 RDS_ENABLE |=> STATUS.group_ready_flag)
		else $error("ready flag missing");
	chk_ready_cause: assert property ($rose(STATUS.group_ready_flag) |-> $past(take_w, 2))
		else $error("ready flag without group");
	chk_ready_hold: assert property ($fell(STATUS.group_ready_flag) && $past(RDS_ENABLE) &&
		$past(RDS_ENABLE, 2) |-> hi_cnt_ff >= READY_HOLD_CYCLES) else $error("ready too short");
	chk_level_code: assert property (s_take ##1 (DETAIL_REPORT_SELECT && RDS_ENABLE && !take_w)
		|=> STATUS[7:0] == lv_ff) else $error("error level wrong");
	chk_sync_follow: assert property (!$past(RESET) |-> STATUS.stream_sync_flag ==
		$past(RDS_ENABLE && DETAIL_REPORT_SELECT && STREAM_IN_SYNC)) else $error("sync wrong");
	chk_irq_start: assert property (s_irq |=> !GENERAL_PIN_OUT[1])
		else $error("pin two pulse missing");
	chk_irq_cause: assert property ($fell(GENERAL_PIN_OUT[1]) && $past(GENERAL_PIN_OE[1]) &&
		$past(PIN_CONFIG[3:2]) == 2'h1 |-> $past(irq_w, 2)) else $error("pulse without cause");
	chk_irq_width: assert property ($rose(GENERAL_PIN_OUT[1]) && $past(GENERAL_PIN_OE[1]) &&
		$past(PIN_CONFIG[3:2]) == 2'h1 |-> lo_cnt_ff >= IRQ_PULSE_CYCLES) else $error("pulse short");
	chk_bus_mode: assert property ($past(RESET) |=> BUS_MODE_VALID && BUS_MODE_THREE_WIRE ==
		$past(GENERAL_PIN_IN[2] && !GENERAL_PIN_IN[0])) else $error("bus mode wrong");
	chk_pull_down: assert property (@(posedge CLK_SYS) disable iff (1'h0)
		PIN_THREE_PULL_DOWN == RESET) else $error("pull-down wrong");
endmodule : rdg_status_props
bind rdg_status_gpio rdg_status_props #(.READY_HOLD_CYCLES(READY_HOLD_CYCLES),
	.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) i_rdg_status_props (.CLK_SYS, .RESET, .RDS_ENABLE,
	.DETAIL_REPORT_SELECT, .GROUP_IRQ_ENABLE, .SEEK_IRQ_ENABLE, .PIN_CONFIG, .GROUP_REPORT,
	.STREAM_IN_SYNC, .SEEK_TUNE_DONE, .GENERAL_PIN_IN, .STATUS, .BUS_MODE_VALID,
	.BUS_MODE_THREE_WIRE, .GENERAL_PIN_OUT, .GENERAL_PIN_OE, .PIN_THREE_PULL_DOWN);
`default_nettype wire

// ===== verif/rdg_host_model.sv
// Host model: counts pin two interrupts and judges block levels.
// Assumes the pin two wire level is worked out by the bench.
`timescale 1ns/1ns
`default_nettype none
module rdg_host_model
	import rdg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic armed,
	input wire logic pin_two,
	input wire rdg_status_type status,
	output logic [7:0] irq_count,
	output logic [3:0] block_usable
);
	logic pin_d_ff;
	// Blocks with six or more errors are discarded
	assign block_usable = {status.block_a_error_level != 2'h3, status.block_b_error_level != 2'h3,
		status.block_c_error_level != 2'h3, status.block_d_error_level != 2'h3};
	// Falling edges count only once powerup has elapsed
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pin_d_ff <= 1'h1;
			irq_count <= 8'h0;
		end else begin
			pin_d_ff <= pin_two;
			if (armed && pin_d_ff && !pin_two) begin
				irq_count <= irq_count + 8'h1;
			end
		end
	end
endmodule : rdg_host_model
`default_nettype wire

// ===== verif/radio_data_status_and_gpio_bench.sv
// Self-checking bench of the radio data status and pin block.
// Assumes small hold counts and a 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module radio_data_status_and_gpio_bench;
	import rdg_pkg::*;
	localparam int RDY = 40;
	localparam int IRQ = 5;
	typedef struct packed {
		logic en, det, val, syn;
		logic [15:0] err;
		rdg_status_type exp;
	} rdg_row_type;
	logic clk, rst, en, det, g_irq, s_irq, gain, sync, seek, stereo, armed;
	logic gain_off, m_valid, three, pull;
	logic [5:0] cfg;
	logic [2:0] ext, pin_w, p_out, p_oe, p_lvl, oe_x, eo;
	logic [7:0] irq_count;
	logic [3:0] usable, ux;
	rdg_group_type grp;
	rdg_status_type status;
	int failures, checks, n0, cnt;
	rdg_row_type rows [7] = '{'{1, 0, 1, 1, 16'h6310, 10'h200}, '{1, 0, 0, 1, 16'h0, 10'h0},
		'{0, 0, 1, 1, 16'h0, 10'h0}, '{1, 1, 1, 0, 16'h0, 10'h0}, '{1, 1, 0, 1, 16'h6310, 10'h31B},
		'{1, 1, 1, 1, 16'hF752, 10'h36F}, '{0, 1, 1, 1, 16'h0, 10'h0}};
	// Pin wire level from the driving party, else the outside level
	assign pin_w = (p_oe & p_out) | (~p_oe & ext);
	rdg_status_gpio #(.READY_HOLD_CYCLES(RDY), .IRQ_PULSE_CYCLES(IRQ)) i_rdg_status_gpio (
		.CLK_SYS(clk), .RESET(rst), .RDS_ENABLE(en), .DETAIL_REPORT_SELECT(det),
		.GROUP_IRQ_ENABLE(g_irq), .SEEK_IRQ_ENABLE(s_irq), .PIN_CONFIG(cfg),
		.GAIN_LOOP_DISABLE(gain), .GROUP_REPORT(grp), .STREAM_IN_SYNC(sync),
		.SEEK_TUNE_DONE(seek), .STEREO_DETECTED(stereo), .GENERAL_PIN_IN(pin_w),
		.STATUS(status), .GAIN_LOOP_OFF(gain_off), .BUS_MODE_VALID(m_valid),
		.BUS_MODE_THREE_WIRE(three), .GENERAL_PIN_OUT(p_out), .GENERAL_PIN_OE(p_oe),
		.GENERAL_PIN_LEVEL(p_lvl), .PIN_THREE_PULL_DOWN(pull));
	rdg_host_model i_rdg_host_model (.clk_sys(clk), .reset(rst), .armed(armed),
		.pin_two(pin_w[1]), .status(status), .irq_count(irq_count), .block_usable(usable));
	// Clock at 4 ns period
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test
	// Reset with a strap level on the pins, then check the bus mode
	task do_reset(input logic [2:0] strap, input int n);
		ext = strap;
		rst = 1'h1;
		tick(n);
		check("pull down", 16'h1, 16'(pull));
		check("status", 16'h0, 16'(status));
		rst = 1'h0;
		tick(1);
		check("bus mode", 16'(2'h2 | (strap[2] & ~strap[0])), 16'({m_valid, three}));
		check("pull down", 16'h0, 16'(pull));
	endtask : do_reset
	task send(input logic val, input logic [15:0] err);
		grp = '{1'h1, val, err};
		tick(1);
		grp.strobe = 1'h0;
	endtask : send
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_of_test();
	end
	// Main sequence
	initial begin
		{failures, checks, en, det, g_irq, s_irq, gain, sync, seek, stereo, armed} = '0;
		grp = '0;
		cfg = 6'h15;
		g_irq = 1'h1;
		do_reset(3'h6, 12);
		armed = 1'h1;
		for (int i = 0; i < 7; i++) begin
			{en, det, sync} = {rows[i].en, rows[i].det, rows[i].syn};
			tick(2);
			n0 = irq_count;
			send(rows[i].val, rows[i].err);
			tick(2);
			check("status", 16'(rows[i].exp), 16'(status));
			ux = {rows[i].exp.block_a_error_level != 2'h3, rows[i].exp.block_b_error_level != 2'h3,
				rows[i].exp.block_c_error_level != 2'h3, rows[i].exp.block_d_error_level != 2'h3};
			check("usable", 16'(ux), 16'(usable));
			tick(60);
			check("pulses", 16'(n0 + rows[i].exp.group_ready_flag), 16'(irq_count));
		end
		en = 1'h0;
		for (int c = 0; c < 4; c++) begin
			cfg = {3{c[1:0]}};
			gain = c[0];
			stereo = (c == 1);
			tick(3);
			oe_x = {c != 0, c != 0, c[1]};
			eo = {3{c[0]}} & oe_x;
			check("pin enable", 16'(oe_x), 16'(p_oe));
			check("pin out", 16'(eo), 16'(p_out & oe_x));
			check("pin level", 16'(eo | (~oe_x & ext)), 16'(p_lvl));
			check("gain off", 16'(c[0]), 16'(gain_off));
		end
		{cfg, en, det} = {6'h15, 2'h2};
		tick(3);
		n0 = irq_count;
		grp = '{1'h1, 1'h1, 16'h0};
		tick(2);
		grp.strobe = 1'h0;
		for (cnt = 0; status.group_ready_flag && cnt < 200; cnt++) tick(1);
		check("hold", 16'h1, 16'(cnt >= RDY + 1 && cnt <= RDY + 2));
		check("pulses", 16'(n0 + 1), 16'(irq_count));
		{s_irq, seek} = 2'h3;
		tick(20);
		check("pulses", 16'(n0 + 2), 16'(irq_count));
		{seek, cfg} = {1'h0, 6'h3D};
		tick(2);
		seek = 1'h1;
		tick(20);
		check("pulses", 16'(n0 + 2), 16'(irq_count));
		{seek, cfg, g_irq} = {1'h0, 6'h15, 1'h0};
		send(1'h1, 16'h0);
		tick(20);
		check("pulses", 16'(n0 + 2), 16'(irq_count));
		do_reset(3'h2, 2);
		end_of_test();
	end
endmodule : radio_data_status_and_gpio_bench
`default_nettype wire
